// *** verilog/lbc_ctrl.sv ***
// lbc_ctrl: host controller that clears all block lock bits of a byte-wide flash
// assumes a flash on the pins below and software on the simple register port
`timescale 1ns/1ps
module lbc_ctrl #(
    parameter int         AW         = 21,
    parameter logic [7:0] CMD_SETUP  = 8'h60,   // clear lock bits setup code
    parameter logic [7:0] CMD_CONFIRM = 8'hD0,  // clear lock bits confirm code
    parameter logic [7:0] CMD_CLRSTAT = 8'h50   // clear status register code
) (
    // clock and reset
    input  wire logic                    CLK_SYS_I,
    input  wire logic                    RST_B_I,
    // software register port
    input  wire logic [lbc_pkg::RA_W-1:0] REG_ADDR_I,
    input  wire logic [7:0]              REG_WDATA_I,
    input  wire logic                    REG_WR_I,
    input  wire logic                    REG_RD_I,
    output logic [7:0]                   REG_RDATA_O,
    // flash pins
    output logic [AW-1:0]                FLASH_ADDR_O,
    output logic [7:0]                   FLASH_DQ_O,
    output logic                         FLASH_DQ_OE_O,
    input  wire logic [7:0]              FLASH_DQ_I,
    output logic                         FLASH_CE_N_O,
    output logic                         FLASH_WE_N_O,
    output logic                         FLASH_OE_N_O,
    output logic                         FLASH_RESET_PROTECT_N_O,
    output logic                         FLASH_OVERRIDE_EN_O,
    input  wire logic                    FLASH_READY_BUSY_I
);
    typedef enum logic [3:0] {
        S_IDLE, S_OVR, S_SETUP, S_CONFIRM, S_WAIT, S_READ, S_CLRSTAT, S_RESET, S_FINISH
    } lbc_state_t;

    lbc_state_t                 st_reg;      // sequencer state
    logic                       issued_reg;  // pin cycle requested in this state
    logic [lbc_pkg::CNT_W-1:0]  tmr_reg;     // settle and pulse timer
    logic [lbc_pkg::POLL_W-1:0] poll_reg;    // ready-pin wait timer
    logic                       clearing_reg; // a clear is in flight
    logic [7:0]                 sr_reg;      // last valid status byte, bit 0 masked
    logic [7:0]                 st_bits_reg; // controller status
    logic                       rb1_reg;     // ready pin sync stage 1
    logic                       rb2_reg;     // ready pin sync stage 2
    logic                       rb3_reg;     // ready pin sync stage 3
    logic                       rb_reg;      // settled ready level
    logic                       go;          // software start strobe
    logic                       do_clrstat;  // software clear-status strobe
    logic                       abort;       // software abort strobe
    logic [7:0]                 sr_rx;       // read byte with reserved bit masked

    lbc_cyc_if #(.AW(AW)) cyc_bus ();

    // one pin cycle engine
    lbc_pin_cycle #(.AW(AW)) u_pin (
        .clk_i   (CLK_SYS_I),
        .rst_b_i (RST_B_I),
        .cyc     (cyc_bus.cyc),
        .addr_o  (FLASH_ADDR_O),
        .dq_o    (FLASH_DQ_O),
        .dq_oe_o (FLASH_DQ_OE_O),
        .ce_n_o  (FLASH_CE_N_O),
        .we_n_o  (FLASH_WE_N_O),
        .oe_n_o  (FLASH_OE_N_O),
        .dq_i    (FLASH_DQ_I)
    );

    // software strobes decoded from the control register write
    assign go         = REG_WR_I && (REG_ADDR_I == lbc_pkg::REG_CTRL)
                        && REG_WDATA_I[lbc_pkg::CTRL_GO];
    assign do_clrstat = REG_WR_I && (REG_ADDR_I == lbc_pkg::REG_CTRL)
                        && REG_WDATA_I[lbc_pkg::CTRL_CLRSTAT];
    assign abort      = REG_WR_I && (REG_ADDR_I == lbc_pkg::REG_CTRL)
                        && REG_WDATA_I[lbc_pkg::CTRL_ABORT];
    assign sr_rx      = cyc_bus.rdata & lbc_pkg::SR_VALID_MASK;

    // ready/busy pin synchroniser; a change counts once stages two and three agree
    always_ff @(posedge CLK_SYS_I) begin
        if (!RST_B_I) begin
            rb1_reg <= 1'b0;
            rb2_reg <= 1'b0;
            rb3_reg <= 1'b0;
            rb_reg  <= 1'b0;
        end else begin
            rb1_reg <= FLASH_READY_BUSY_I;
            rb2_reg <= rb1_reg;
            rb3_reg <= rb2_reg;
            if (rb2_reg == rb3_reg) begin
                rb_reg <= rb3_reg;
            end
        end
    end

    // software read port, data one cycle after the strobe
    always_ff @(posedge CLK_SYS_I) begin
        if (!RST_B_I) begin
            REG_RDATA_O <= lbc_pkg::BYTE_ZERO;
        end else if (REG_RD_I) begin
            if (REG_ADDR_I == lbc_pkg::REG_STATUS) begin
                REG_RDATA_O <= st_bits_reg;
            end else if (REG_ADDR_I == lbc_pkg::REG_LAST_SR) begin
                REG_RDATA_O <= sr_reg;
            end else begin
                REG_RDATA_O <= lbc_pkg::BYTE_ZERO;  // unmapped
            end
        end else begin
            REG_RDATA_O <= lbc_pkg::BYTE_ZERO;
        end
    end

    // sequencer: override, two-cycle command, polling, error clean-up
    always_ff @(posedge CLK_SYS_I) begin
        if (!RST_B_I) begin
            st_reg        <= S_IDLE;
            issued_reg    <= 1'b0;
            tmr_reg       <= '0;
            poll_reg      <= '0;
            clearing_reg  <= 1'b0;
            sr_reg        <= lbc_pkg::BYTE_ZERO;
            st_bits_reg   <= lbc_pkg::BYTE_ZERO;
            cyc_bus.req   <= 1'b0;
            cyc_bus.wr    <= 1'b0;
            cyc_bus.addr  <= '0;
            cyc_bus.wdata <= lbc_pkg::BYTE_ZERO;
            FLASH_RESET_PROTECT_N_O <= 1'b0;
            FLASH_OVERRIDE_EN_O     <= 1'b0;
        end else begin
            cyc_bus.req <= 1'b0;
            FLASH_RESET_PROTECT_N_O <= 1'b1;
            case (st_reg)
                S_IDLE: begin
                    issued_reg <= 1'b0;
                    if (abort) begin
                        tmr_reg <= lbc_pkg::RP_CYC;
                        st_reg  <= S_RESET;
                    end else if (go) begin
                        // override only for a set master lock; the level switches
                        // cleanly between the two states while idle
                        FLASH_OVERRIDE_EN_O <= REG_WDATA_I[lbc_pkg::CTRL_MASTER];
                        st_bits_reg <= (st_bits_reg & (8'h01 << lbc_pkg::ST_UNKNOWN))
                                       | (8'h01 << lbc_pkg::ST_BUSY)
                                       | (REG_WDATA_I[lbc_pkg::CTRL_MASTER]
                                          ? (8'h01 << lbc_pkg::ST_OVR) : 8'h00);
                        clearing_reg <= 1'b1;
                        tmr_reg      <= lbc_pkg::OVR_CYC;
                        st_reg       <= S_OVR;
                    end else if (do_clrstat) begin
                        st_bits_reg[lbc_pkg::ST_BUSY] <= 1'b1;
                        st_reg <= S_CLRSTAT;
                    end
                end
                S_OVR: begin
                    // let the pin reach its level before the command
                    if (tmr_reg <= 8'h01) begin
                        st_reg <= S_SETUP;
                    end else begin
                        tmr_reg <= tmr_reg - 8'h01;
                    end
                end
                S_SETUP, S_CONFIRM, S_CLRSTAT: begin
                    // command writes: setup then confirm, or a lone clear-status
                    if (!issued_reg) begin
                        cyc_bus.req   <= 1'b1;
                        cyc_bus.wr    <= 1'b1;
                        cyc_bus.wdata <= (st_reg == S_SETUP) ? CMD_SETUP
                                       : (st_reg == S_CONFIRM) ? CMD_CONFIRM : CMD_CLRSTAT;
                        issued_reg    <= 1'b1;
                    end else if (cyc_bus.done) begin
                        issued_reg <= 1'b0;
                        poll_reg   <= lbc_pkg::POLL_CYC;
                        st_reg     <= (st_reg == S_SETUP) ? S_CONFIRM
                                    : (st_reg == S_CONFIRM) ? S_WAIT : S_FINISH;
                    end
                end
                S_WAIT: begin
                    // completion by ready pin, or poll anyway after the wait
                    if (abort) begin
                        tmr_reg <= lbc_pkg::RP_CYC;
                        st_reg  <= S_RESET;
                    end else if (rb_reg || poll_reg == '0) begin
                        st_reg <= S_READ;
                    end else begin
                        poll_reg <= poll_reg - 10'h001;
                    end
                end
                S_READ: begin
                    // reads now return status, no mode command needed
                    if (!issued_reg) begin
                        cyc_bus.req <= 1'b1;
                        cyc_bus.wr  <= 1'b0;
                        issued_reg  <= 1'b1;
                    end else if (cyc_bus.done) begin
                        issued_reg <= 1'b0;
                        if (!sr_rx[lbc_pkg::SR_READY]) begin
                            // lower bits meaningless while busy
                            poll_reg <= lbc_pkg::POLL_CYC;
                            st_reg   <= S_WAIT;
                        end else begin
                            sr_reg <= sr_rx;
                            st_bits_reg[lbc_pkg::ST_BADSEQ] <= sr_rx[lbc_pkg::SR_ERASE_ERR]
                                && sr_rx[lbc_pkg::SR_WRITE_ERR];
                            st_bits_reg[lbc_pkg::ST_LOWSUP] <= sr_rx[lbc_pkg::SR_ERASE_ERR]
                                && sr_rx[lbc_pkg::SR_SUPPLY];
                            st_bits_reg[lbc_pkg::ST_PROT]   <= sr_rx[lbc_pkg::SR_ERASE_ERR]
                                && sr_rx[lbc_pkg::SR_PROTECT];
                            st_bits_reg[lbc_pkg::ST_FAIL] <= sr_rx[lbc_pkg::SR_ERASE_ERR];
                            // success leaves every lock bit known cleared
                            st_bits_reg[lbc_pkg::ST_UNKNOWN] <= sr_rx[lbc_pkg::SR_ERASE_ERR]
                                && st_bits_reg[lbc_pkg::ST_UNKNOWN];
                            clearing_reg <= 1'b0;
                            // an error is followed by a clear-status write
                            st_reg <= sr_rx[lbc_pkg::SR_ERASE_ERR] ? S_CLRSTAT : S_FINISH;
                        end
                    end
                end
                S_RESET: begin
                    // reset pulse returns the device status to ready
                    FLASH_RESET_PROTECT_N_O <= 1'b0;
                    if (tmr_reg <= 8'h01) begin
                        if (clearing_reg) begin
                            // an interrupted clear leaves the bits unknown: repeat it
                            st_bits_reg[lbc_pkg::ST_UNKNOWN] <= 1'b1;
                            tmr_reg <= lbc_pkg::OVR_CYC;
                            st_reg  <= S_OVR;
                        end else begin
                            st_reg <= S_IDLE;
                        end
                    end else begin
                        tmr_reg <= tmr_reg - 8'h01;
                    end
                end
                default: begin
                    // drop override and report completion
                    FLASH_OVERRIDE_EN_O <= 1'b0;
                    st_bits_reg[lbc_pkg::ST_BUSY] <= 1'b0;
                    st_bits_reg[lbc_pkg::ST_DONE] <= 1'b1;
                    st_bits_reg[lbc_pkg::ST_OVR]  <= 1'b0;
                    st_reg <= S_IDLE;
                end
            endcase
        end
    end
endmodule // lbc_ctrl

// *** verilog/lbc_pkg.sv ***
// lbc_pkg: constants for the lock-bit clear controller
// assumes a single 200 MHz system clock; all pin timing is derived from it
package lbc_pkg;
    // system clock rate
    localparam int CLK_MHZ       = 200;
    // pin timing in ns
    localparam int T_SETUP_NS    = 10;   // address/data set up before strobe
    localparam int T_WP_NS       = 50;   // write strobe low time
    localparam int T_ACC_NS      = 100;  // read strobe low time before sampling
    localparam int T_HOLD_NS     = 10;   // hold after strobe release
    localparam int T_RP_NS       = 100;  // reset/protect low pulse
    localparam int T_OVR_NS      = 100;  // override level settle time
    // counters
    localparam int CNT_W         = 8;
    localparam logic [CNT_W-1:0] SETUP_CYC = CNT_W'((T_SETUP_NS * CLK_MHZ + 999) / 1000);
    localparam logic [CNT_W-1:0] WP_CYC    = CNT_W'((T_WP_NS * CLK_MHZ + 999) / 1000);
    localparam logic [CNT_W-1:0] ACC_CYC   = CNT_W'((T_ACC_NS * CLK_MHZ + 999) / 1000);
    localparam logic [CNT_W-1:0] HOLD_CYC  = CNT_W'((T_HOLD_NS * CLK_MHZ + 999) / 1000);
    localparam logic [CNT_W-1:0] RP_CYC    = CNT_W'((T_RP_NS * CLK_MHZ + 999) / 1000);
    localparam logic [CNT_W-1:0] OVR_CYC   = CNT_W'((T_OVR_NS * CLK_MHZ + 999) / 1000);
    // longest wait for the ready pin before a status read anyway
    localparam int POLL_W        = 10;
    localparam logic [POLL_W-1:0] POLL_CYC = 10'h3E8;
    // software register map
    localparam int RA_W          = 4;
    localparam logic [RA_W-1:0] REG_CTRL    = 4'h0;
    localparam logic [RA_W-1:0] REG_STATUS  = 4'h1;
    localparam logic [RA_W-1:0] REG_LAST_SR = 4'h2;
    // control register bits (write only, one-shot)
    localparam int CTRL_GO       = 0;    // start a clear of all block lock bits
    localparam int CTRL_MASTER   = 1;    // master lock bit is known to be set
    localparam int CTRL_CLRSTAT  = 2;    // send a clear-status command
    localparam int CTRL_ABORT    = 3;    // pulse reset/protect low
    // controller status register bits
    localparam int ST_BUSY       = 0;
    localparam int ST_DONE       = 1;
    localparam int ST_FAIL       = 2;
    localparam int ST_UNKNOWN    = 3;
    localparam int ST_BADSEQ     = 4;
    localparam int ST_LOWSUP     = 5;
    localparam int ST_PROT       = 6;
    localparam int ST_OVR        = 7;
    // device operation_status bit positions
    localparam int SR_READY      = 7;
    localparam int SR_ERASE_ERR  = 5;
    localparam int SR_WRITE_ERR  = 4;
    localparam int SR_SUPPLY     = 3;
    localparam int SR_PROTECT    = 1;
    localparam logic [7:0] SR_VALID_MASK = 8'hFE;
    localparam logic [7:0] BYTE_ZERO     = 8'h00;
endpackage

// *** verilog/lbc_cyc_if.sv ***
// lbc_cyc_if: request/answer pair for one flash pin cycle
// assumes both ends share the system clock
`timescale 1ns/1ps
interface lbc_cyc_if #(parameter int AW = 21);
    logic          req;    // one-cycle request
    logic          wr;     // 1 write, 0 read
    logic [AW-1:0] addr;   // device address
    logic [7:0]    wdata;  // write byte
    logic          done;   // one-cycle completion
    logic [7:0]    rdata;  // read byte, valid with done
    modport ctrl (output req, output wr, output addr, output wdata, input done, input rdata);
    modport cyc  (input req, input wr, input addr, input wdata, output done, output rdata);
endinterface

// *** verilog/lbc_pin_cycle.sv ***
// lbc_pin_cycle: runs one asynchronous write or read cycle on the flash pins
// assumes requests arrive only while no cycle is running
`timescale 1ns/1ps
module lbc_pin_cycle #(
    parameter int AW = 21
) (
    // clock and reset
    input  wire logic          clk_i,
    input  wire logic          rst_b_i,
    // request side
    lbc_cyc_if.cyc             cyc,
    // flash pins
    output logic [AW-1:0]      addr_o,
    output logic [7:0]         dq_o,
    output logic               dq_oe_o,
    output logic               ce_n_o,
    output logic               we_n_o,
    output logic               oe_n_o,
    input  wire logic [7:0]    dq_i
);
    typedef enum logic [1:0] {C_IDLE, C_SETUP, C_STROBE, C_HOLD} lbc_cyc_st_t;
    lbc_cyc_st_t               st_reg;        // cycle phase
    logic [lbc_pkg::CNT_W-1:0] cnt_reg;       // phase timer
    logic                      wr_reg;        // kind of current cycle
    logic [7:0]                s1_reg;        // data sync stage 1
    logic [7:0]                s2_reg;        // data sync stage 2
    logic [7:0]                s3_reg;        // data sync stage 3
    logic [7:0]                rd_reg;        // settled read byte

    // three-stage synchroniser on the data pins
    always_ff @(posedge clk_i) begin
        s1_reg <= dq_i;
        s2_reg <= s1_reg;
        s3_reg <= s2_reg;
        if (s2_reg == s3_reg) begin
            rd_reg <= s3_reg;   // take a byte once two stages agree
        end
    end

    // phase sequencer driving the strobes
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            st_reg   <= C_IDLE;
            cnt_reg  <= '0;
            wr_reg   <= 1'b0;
            addr_o   <= '0;
            dq_o     <= lbc_pkg::BYTE_ZERO;
            dq_oe_o  <= 1'b0;
            ce_n_o   <= 1'b1;
            we_n_o   <= 1'b1;
            oe_n_o   <= 1'b1;
            cyc.done  <= 1'b0;
            cyc.rdata <= lbc_pkg::BYTE_ZERO;
        end else begin
            cyc.done <= 1'b0;
            case (st_reg)
                C_IDLE: begin
                    if (cyc.req) begin
                        // address, data and chip select go out first
                        addr_o  <= cyc.addr;
                        dq_o    <= cyc.wdata;
                        dq_oe_o <= cyc.wr;
                        wr_reg  <= cyc.wr;
                        ce_n_o  <= 1'b0;
                        cnt_reg <= lbc_pkg::SETUP_CYC;
                        st_reg  <= C_SETUP;
                    end
                end
                C_SETUP: begin
                    if (cnt_reg <= 8'h01) begin
                        we_n_o  <= ~wr_reg;
                        oe_n_o  <= wr_reg;
                        cnt_reg <= wr_reg ? lbc_pkg::WP_CYC : lbc_pkg::ACC_CYC;
                        st_reg  <= C_STROBE;
                    end else begin
                        cnt_reg <= cnt_reg - 8'h01;
                    end
                end
                C_STROBE: begin
                    if (cnt_reg <= 8'h01) begin
                        // rising write strobe latches the byte in the device
                        we_n_o    <= 1'b1;
                        oe_n_o    <= 1'b1;
                        cyc.rdata <= rd_reg;
                        cnt_reg   <= lbc_pkg::HOLD_CYC;
                        st_reg    <= C_HOLD;
                    end else begin
                        cnt_reg <= cnt_reg - 8'h01;
                    end
                end
                default: begin
                    if (cnt_reg <= 8'h01) begin
                        dq_oe_o  <= 1'b0;
                        ce_n_o   <= 1'b1;
                        cyc.done <= 1'b1;
                        st_reg   <= C_IDLE;
                    end else begin
                        cnt_reg <= cnt_reg - 8'h01;
                    end
                end
            endcase
        end
    end
endmodule // lbc_pin_cycle

// *** test/lbc_ctrl_properties.sv ***
// lbc_ctrl_chk: pin and register-port properties of lbc_ctrl
// assumes it is bound into lbc_ctrl and sees only its ports
`timescale 1ns/1ps
module lbc_ctrl_chk (
    // clock, reset and register port
    input wire logic       CLK_SYS_I,
    input wire logic       RST_B_I,
    input wire logic       REG_RD_I,
    input wire logic [7:0] REG_RDATA_O,
    // flash pins
    input wire logic [7:0] FLASH_DQ_O,
    input wire logic       FLASH_DQ_OE_O,
    input wire logic       FLASH_CE_N_O,
    input wire logic       FLASH_WE_N_O,
    input wire logic       FLASH_OE_N_O,
    input wire logic       FLASH_RESET_PROTECT_N_O,
    input wire logic       FLASH_OVERRIDE_EN_O
);
    default clocking @(posedge CLK_SYS_I); endclocking
    default disable iff (!RST_B_I);
    rdata_idle_a: assert property (!$past(REG_RD_I) |-> REG_RDATA_O == 8'h00)
        else $error("read data seen outside its cycle");
    strobes_apart_a: assert property (!(!FLASH_WE_N_O && !FLASH_OE_N_O))
        else $error("write and read strobes low together");
    write_driven_a: assert property (!FLASH_WE_N_O |-> !FLASH_CE_N_O && FLASH_DQ_OE_O)
        else $error("write strobe without select or data drive");
    read_released_a: assert property (!FLASH_OE_N_O |-> !FLASH_CE_N_O && !FLASH_DQ_OE_O)
        else $error("read strobe while data is driven");
    we_width_a: assert property ($fell(FLASH_WE_N_O) |-> !FLASH_WE_N_O [*8])
        else $error("write strobe too short");
    wdata_hold_a: assert property (!FLASH_WE_N_O && !$past(FLASH_WE_N_O) |-> $stable(FLASH_DQ_O))
        else $error("write data moved under the strobe");
    rp_pulse_a: assert property ($fell(FLASH_RESET_PROTECT_N_O) |-> !FLASH_RESET_PROTECT_N_O [*8])
        else $error("reset pulse too short");
    ovr_steady_a: assert property (!FLASH_CE_N_O |-> $stable(FLASH_OVERRIDE_EN_O))
        else $error("override changed during a pin cycle");
endmodule // lbc_ctrl_chk
bind lbc_ctrl lbc_ctrl_chk u_chk (.CLK_SYS_I, .RST_B_I, .REG_RD_I, .REG_RDATA_O, .FLASH_DQ_O,
    .FLASH_DQ_OE_O, .FLASH_CE_N_O, .FLASH_WE_N_O, .FLASH_OE_N_O, .FLASH_RESET_PROTECT_N_O,
    .FLASH_OVERRIDE_EN_O);

// *** test/lbc_flash_model.sv ***
// lbc_flash_model: behavioural flash, lock-bit clear and status only
// assumes the controller pins and the bench clock; a clear takes 200 cycles
`timescale 1ns/1ps
module lbc_flash_model (
    // pins and bench knobs
    input  wire logic       clk_i,
    input  wire logic [7:0] dq_i,
    input  wire logic       ce_n_i,
    input  wire logic       we_n_i,
    input  wire logic       oe_n_i,
    input  wire logic       rp_n_i,
    input  wire logic       ovr_i,
    input  wire logic       master_i, // master lock is fixed, never cleared
    input  wire logic [1:0] fault_i,
    output logic [7:0]      dq_o,
    output logic            ready_o,
    output logic [7:0]      sr_o,     // suspend and reserved bits stay 0
    output logic [3:0]      locks_o
);
    logic we_d = 1'b1;
    logic setup_reg = 1'b0;
    int   busy = 0;
    initial sr_o = 8'h80;
    initial locks_o = 4'hF;
    // only the clear below and a reset during a clear move the lock bits; other commands leave them alone
    assign ready_o = (busy == 0);
    // reads always see status; a released bus shows the inverse
    assign dq_o = (!oe_n_i && !ce_n_i) ? sr_o : ~sr_o;
    always @(posedge clk_i) begin
        we_d <= we_n_i;
        if (!rp_n_i) begin // reset: ready, clean; an aborted clear spoils locks
            sr_o <= 8'h80;
            setup_reg <= 1'b0;
            busy <= 0;
            if (busy != 0) locks_o <= 4'h5;
        end else if (we_n_i && !we_d && !ce_n_i) begin
            if (setup_reg && (dq_i != 8'hD0 || fault_i == 2'd2)) sr_o <= 8'hB0;
            else if (setup_reg) begin
                sr_o <= 8'h00;
                busy <= 200;
            end else if (dq_i == 8'h50) sr_o <= 8'h80;
            setup_reg <= !setup_reg && dq_i == 8'h60;
        end else if (busy != 0) begin
            busy <= busy - 1;
            if (busy == 1 && fault_i == 2'd1) sr_o <= 8'hA8;
            else if (busy == 1 && master_i && !ovr_i) sr_o <= 8'hA2;
            else if (busy == 1) begin // all locks at once
                sr_o <= 8'h80;
                locks_o <= 4'h0;
            end
        end
    end
endmodule // lbc_flash_model

// *** test/testbench.sv ***
// testbench: drives lbc_ctrl through its register port against a flash model
// assumes lbc_pkg, lbc_ctrl, lbc_flash_model and the bound checker are compiled
`timescale 1ns/1ps
module testbench;
    logic clk = 0, rst_b = 0, wr = 0, rd = 0, master = 0, oe, ovr, ce_n, we_n, oe_n, rp_n, rdy;
    logic [3:0] addr = 4'h0, locks;
    logic [7:0] wdata = 8'h00, rdata, dq_c, dq_f, bus, sr;
    logic [1:0] fault = 2'd0;
    int fails = 0, cmp_count = 0, cyc = 0;
    always #2.5 clk = ~clk;
    assign bus = oe ? dq_c : dq_f; // shared data wire
    lbc_ctrl dut (.CLK_SYS_I(clk), .RST_B_I(rst_b), .REG_ADDR_I(addr), .REG_WDATA_I(wdata),
        .REG_WR_I(wr), .REG_RD_I(rd), .REG_RDATA_O(rdata), .FLASH_ADDR_O(), .FLASH_DQ_O(dq_c),
        .FLASH_DQ_OE_O(oe), .FLASH_DQ_I(bus), .FLASH_CE_N_O(ce_n), .FLASH_WE_N_O(we_n),
        .FLASH_OE_N_O(oe_n), .FLASH_RESET_PROTECT_N_O(rp_n), .FLASH_OVERRIDE_EN_O(ovr),
        .FLASH_READY_BUSY_I(rdy));
    lbc_flash_model u_flash (.clk_i(clk), .dq_i(bus), .ce_n_i(ce_n), .we_n_i(we_n), .oe_n_i(oe_n),
        .rp_n_i(rp_n), .ovr_i(ovr), .master_i(master), .fault_i(fault), .dq_o(dq_f),
        .ready_o(rdy), .sr_o(sr), .locks_o(locks));
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input logic [7:0] m);
        cmp_count++;
        if ((got & m) !== exp) begin
            fails++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got & m, exp);
        end
    endtask
    // one clear: start, optional abort, poll, then check status, last byte, locks
    task automatic run(input logic [7:0] c, input logic [1:0] f, input logic m, input logic ab,
                       input logic [7:0] es, input logic [7:0] ls, input logic [3:0] lk);
        logic [7:0] d;
        int n;
        fault = f;
        master = m;
        wr_reg(lbc_pkg::REG_CTRL, c);
        n = 0;
        while (ab && rdy && n < 200) begin
            @(posedge clk);
            n++;
        end
        if (ab) repeat (60) @(posedge clk);
        if (ab) wr_reg(lbc_pkg::REG_CTRL, 8'h08);
        if (ab) begin
            repeat (4) @(posedge clk);
            chk({4'h0, locks}, 8'h05, 8'hFF);
            repeat (25) @(posedge clk);
            rd_reg(lbc_pkg::REG_STATUS, d);
            chk(d, 8'h89, 8'hFF);
        end
        n = 0;
        do begin
            rd_reg(lbc_pkg::REG_STATUS, d);
            n++;
        end while (d[0] !== 1'b0 && n < 500);
        chk(d, es, 8'h7F);
        rd_reg(lbc_pkg::REG_LAST_SR, d);
        chk(d, ls, 8'hFF);
        chk({4'h0, locks}, {4'h0, lk}, 8'hFF);
        chk(sr, 8'h80, 8'hFF);
    endtask
    task automatic report_and_stop();
        if (fails == 0 && cmp_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // hang guard, well above the few thousand cycles the tests need
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fails++;
            report_and_stop();
        end
    end
    initial begin
        logic [7:0] d;
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        run(8'h01, 2'd1, 1'b0, 1'b0, 8'h26, 8'hA8, 4'hF);
        run(8'h01, 2'd2, 1'b0, 1'b0, 8'h16, 8'hB0, 4'hF);
        run(8'h01, 2'd0, 1'b1, 1'b0, 8'h46, 8'hA2, 4'hF);
        run(8'h03, 2'd0, 1'b1, 1'b0, 8'h02, 8'h80, 4'h0);
        run(8'h01, 2'd0, 1'b0, 1'b0, 8'h02, 8'h80, 4'h0);
        run(8'h03, 2'd0, 1'b1, 1'b1, 8'h02, 8'h80, 4'h0);
        wr_reg(lbc_pkg::REG_CTRL, 8'h04);
        rd_reg(lbc_pkg::REG_STATUS, d);
        chk(d, 8'h03, 8'hFF);
        repeat (30) @(posedge clk);
        rd_reg(lbc_pkg::REG_STATUS, d);
        chk(d, 8'h02, 8'hFF);
        rd_reg(4'hF, d);
        chk(d, 8'h00, 8'hFF);
        report_and_stop();
    end
endmodule // testbench
